// [bench/stc_clk_src.sv]
`timescale 1ns/1ps

// External count source: stands low outside a burst, drives one pin only
module stc_clk_src #(
	parameter int HALF = 2
) (
	input  wire logic clk_sys,
	input  wire logic run,
	input  wire logic use_osc,
	output logic      osc_input_pin,
	output logic      ext_clock_pin,
	output int        rise_cnt
);
	logic lvl;
	int   ph;

	initial begin
		lvl = 1'b0;
		ph = 0;
		rise_cnt = 0;
	end

	// Each level is held HALF cycles, so the synchroniser never misses one
	always @(posedge clk_sys) begin
		if (!run) begin
			lvl <= 1'b0;
			ph <= 0;
		end else if (ph == HALF - 1) begin
			lvl <= !lvl;
			ph <= 0;
			if (!lvl)
				rise_cnt <= rise_cnt + 1;
		end else
			ph <= ph + 1;
	end

	assign osc_input_pin = use_osc && lvl;
	assign ext_clock_pin = !use_osc && lvl;
endmodule

// [bench/stc_timer_assertions.sv]
`timescale 1ns/1ps

module stc_timer_assertions
	import stc_pkg::*;
(
	input wire logic              clk_sys,
	input wire logic              arst_n,
	input wire logic              soft_rst_n,
	input wire logic              sleep_mode,
	input wire logic              osc_input_pin,
	input wire logic              ext_clock_pin,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic              overflow_flag,
	input wire logic              overflow_irq_enable,
	input wire logic              osc_enable
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	logic ctl_wr;
	logic flag_wr;
	logic unmapped;
	assign ctl_wr = reg_wr && reg_addr == OFF_CONTROL;
	assign flag_wr = reg_wr && reg_addr == OFF_FLAG_REG;
	assign unmapped = !(reg_addr inside {OFF_FLAG_REG, OFF_COUNT_LOW, OFF_COUNT_HIGH,
		OFF_CONTROL, OFF_ENABLE_REG});

	a_osc_follow: assert property (
		ctl_wr |-> ##2 osc_enable == $past(reg_wdata[BIT_OSC_ENABLE], 2))
		else $error("osc enable does not follow control write");
	a_osc_cause: assert property (
		$changed(osc_enable) |-> $past(ctl_wr, 2))
		else $error("osc enable moved without control write");
	a_flag_sticky: assert property (
		overflow_flag && soft_rst_n && !flag_wr |=> overflow_flag)
		else $error("overflow flag dropped by itself");
	a_flag_set_wr: assert property (
		flag_wr && reg_wdata[BIT_OVF] && soft_rst_n |=> overflow_flag)
		else $error("flag write of one not taken");
	a_soft_clears: assert property (
		!soft_rst_n ##1 !soft_rst_n |=> !overflow_irq_enable)
		else $error("enable kept through other reset");
	a_flag_read: assert property (
		reg_rd && reg_addr == OFF_FLAG_REG |=> reg_rdata == {7'h00, $past(overflow_flag)})
		else $error("flag register read wrong");
	a_enable_high_zero: assert property (
		reg_rd && reg_addr == OFF_ENABLE_REG |=> reg_rdata[7:1] == 7'h00)
		else $error("enable register upper bits not zero");
	a_ctl_top_zero: assert property (
		reg_rd && reg_addr == OFF_CONTROL |=> reg_rdata[7:6] == 2'h0)
		else $error("control bits 7:6 not zero");
	a_unmapped_zero: assert property (
		reg_rd && unmapped |=> reg_rdata == RD_IDLE)
		else $error("unmapped read not zero");

	c_ctl_wr: cover property (ctl_wr);
	c_overflow: cover property ($rose(overflow_flag));
	c_soft_rst: cover property (!soft_rst_n ##1 !soft_rst_n);
endmodule

// [bench/stc_timer_tb.sv]
`timescale 1ns/1ps

module stc_timer_tb;
	import stc_pkg::*;

	logic              clk_sys, arst_n, soft_rst_n, sleep_mode, reg_wr, reg_rd;
	logic              osc_input_pin, ext_clock_pin, run, use_osc;
	logic              overflow_flag, overflow_irq_enable, osc_enable;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_v, rd_h;
	int                num_errors, cmp_count, rise_cnt, r0, ex;
	logic [7:0]        ctl [7] = '{8'h07, 8'h0f, 8'h0f, 8'h06, 8'h03, 8'h03, 8'h27};
	bit                osc [7] = '{0, 1, 0, 0, 0, 0, 0};
	bit                slp [7] = '{0, 0, 0, 0, 1, 0, 0};
	int                dv [7] = '{1, 1, 0, 0, 0, 1, 4};
	logic [ADDR_W-1:0] ad [6] = '{OFF_CONTROL, OFF_FLAG_REG, OFF_ENABLE_REG,
		OFF_COUNT_LOW, OFF_COUNT_HIGH, 8'h11};

	stc_timer stc_timer_i (.clk_sys, .arst_n, .soft_rst_n, .sleep_mode, .osc_input_pin,
		.ext_clock_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.overflow_flag, .overflow_irq_enable, .osc_enable);
	stc_clk_src stc_clk_src_i (.clk_sys, .run, .use_osc, .osc_input_pin, .ext_clock_pin,
		.rise_cnt);

	// ------------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------------
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		@(posedge clk_sys);
	endtask

	task automatic chk(input string n, input logic [15:0] lo, input logic [15:0] hi,
		input logic [15:0] v);
		cmp_count++;
		if ((v === lo) || (v > lo && v <= hi))
			return;
		num_errors++;
		$display("CHECK FAILED %s expected %0h..%0h seen %0h", n, lo, hi, v);
	endtask

	// Stops the count first so the two byte reads belong together
	task automatic chk_cnt(input string n, input int lo, input int hi);
		wr(OFF_CONTROL, 8'h00);
		rd(OFF_COUNT_LOW, rd_v);
		rd(OFF_COUNT_HIGH, rd_h);
		chk(n, 16'(lo), 16'(hi), {rd_h, rd_v});
	endtask

	task automatic cfg(input logic [7:0] c);
		wr(OFF_CONTROL, 8'h00);
		wr(OFF_COUNT_LOW, 8'h00);
		wr(OFF_COUNT_HIGH, 8'h00);
		wr(OFF_CONTROL, c);
	endtask

	task automatic stop_test();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	initial begin
		#(25 * 10000);
		num_errors++;
		stop_test();
	end

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		{arst_n, soft_rst_n, sleep_mode, reg_wr, reg_rd, run, use_osc} = 7'b0100000;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		num_errors = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		wr(8'h11, 8'hff);
		foreach (ad[i]) begin
			rd(ad[i], rd_v);
			chk("reset value", 16'h0, 16'h0, {8'h00, rd_v});
		end
		wr(OFF_CONTROL, 8'hff);
		rd(OFF_CONTROL, rd_v);
		chk("control", 16'h3f, 16'h3f, {8'h00, rd_v});
		chk("osc_enable", 16'h1, 16'h1, {15'h0, osc_enable});
		wr(OFF_CONTROL, 8'h00);
		wr(OFF_COUNT_LOW, 8'h5a);
		wr(OFF_COUNT_HIGH, 8'ha5);
		chk_cnt("count bytes", 'ha55a, 'ha55a);
		for (int i = 0; i < 4; i++) begin
			cfg({2'b00, i[1:0], 1'b0, i[0], 2'b01});
			repeat (256) @(posedge clk_sys);
			chk_cnt("timer count", (64 >> i) - 1, (64 >> i) + 1);
		end
		foreach (ctl[k]) begin
			sleep_mode <= slp[k];
			cfg(ctl[k]);
			r0 = rise_cnt;
			use_osc <= osc[k];
			run <= 1'b1;
			repeat (36) @(posedge clk_sys);
			run <= 1'b0;
			repeat (10) @(posedge clk_sys);
			sleep_mode <= 1'b0;
			ex = dv[k] ? (rise_cnt - r0 - 1) / dv[k] : 0;
			chk_cnt("edge count", ex - (dv[k] > 1), ex);
		end
		wr(OFF_ENABLE_REG, 8'h01);
		rd(OFF_ENABLE_REG, rd_v);
		chk("irq enable", 16'h1, 16'h1, {8'h00, rd_v});
		wr(OFF_COUNT_LOW, 8'hff);
		wr(OFF_COUNT_HIGH, 8'hff);
		wr(OFF_CONTROL, 8'h01);
		repeat (8) @(posedge clk_sys);
		chk("overflow flag", 16'h1, 16'h1, {15'h0, overflow_flag});
		soft_rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		soft_rst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk("soft reset", 16'h0, 16'h0, {14'h0, overflow_flag, overflow_irq_enable});
		@(posedge clk_sys);
		rd(OFF_CONTROL, rd_v);
		chk("control kept", 16'h1, 16'h1, {8'h00, rd_v});
		chk_cnt("count kept", 1, 16);
		wr(OFF_FLAG_REG, 8'h01);
		rd(OFF_FLAG_REG, rd_v);
		chk("flag write", 16'h1, 16'h1, {8'h00, rd_v});
		wr(OFF_FLAG_REG, 8'h00);
		stop_test();
	end
endmodule

bind stc_timer stc_timer_assertions stc_timer_assertions_i (.clk_sys, .arst_n, .soft_rst_n,
	.sleep_mode, .osc_input_pin, .ext_clock_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .overflow_flag, .overflow_irq_enable, .osc_enable);

// [core/stc_pkg.sv]
package stc_pkg;

	// ------------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 16;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_FLAG_REG   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_COUNT_LOW  = 8'h0e;
	localparam logic [ADDR_W-1:0] OFF_COUNT_HIGH = 8'h0f;
	localparam logic [ADDR_W-1:0] OFF_CONTROL    = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_ENABLE_REG = 8'h8c;

	// ------------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------------
	localparam int CTL_W           = 6;
	localparam int BIT_COUNTER_ON  = 0;
	localparam int BIT_CLK_SRC_SEL = 1;
	localparam int BIT_SYNC_DIS_N  = 2;
	localparam int BIT_OSC_ENABLE  = 3;
	localparam int BIT_PRESCALE_LO = 4;
	localparam int BIT_PRESCALE_HI = 5;
	localparam int PRESCALE_W      = 2;

	// Overflow flag and its enable sit in bit 0 of their registers
	localparam int BIT_OVF = 0;

	// ------------------------------------------------------------------
	// Reset values and count constants
	// ------------------------------------------------------------------
	localparam logic [CTL_W-1:0]  CTL_RST   = 6'h00;
	localparam logic [CNT_W-1:0]  CNT_RST   = 16'h0000;
	localparam logic [DATA_W-1:0] RD_IDLE   = 8'h00;
	localparam logic [CNT_W-1:0]  CNT_MAX   = 16'hffff;
	localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;

	// ------------------------------------------------------------------
	// Instruction clock: system oscillator divided by four
	// ------------------------------------------------------------------
	localparam int              QDIV_W    = 2;
	localparam logic [QDIV_W-1:0] QDIV_LAST = 2'h3;
	localparam logic [QDIV_W-1:0] QDIV_ONE  = 2'h1;
	localparam logic [QDIV_W-1:0] QDIV_RST  = 2'h0;

	// Prescaler ripple stages: divide by 1, 2, 4 or 8
	localparam int PRESCALE_STAGES = 3;

endpackage

// [core/stc_prescaler.sv]
`timescale 1ns/1ps

// Ripple divider kept in the system clock domain: each stage advances
// when the stage below it falls, exactly as a chain of toggle flops would.
module stc_prescaler
	import stc_pkg::*;
#(
	parameter int STAGES = PRESCALE_STAGES,
	parameter int SEL_W  = PRESCALE_W
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             clear,
	input  wire logic             in_pulse,
	input  wire logic [SEL_W-1:0] div_sel,
	output logic                  out_pulse
);

	logic [STAGES-1:0] stage_r;
	logic [STAGES:0]   carry;
	logic [STAGES:0]   rise;

	assign carry[0] = in_pulse;
	assign rise[0]  = in_pulse;

	// ------------------------------------------------------------------
	// Ripple chain
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < STAGES; gi++) begin : g_stage
			assign carry[gi+1] = carry[gi] & stage_r[gi];
			assign rise[gi+1]  = carry[gi] & ~stage_r[gi];
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					stage_r[gi] <= 1'b0;
				end else if (clear) begin
					stage_r[gi] <= 1'b0;
				end else if (carry[gi]) begin
					stage_r[gi] <= ~stage_r[gi];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Tap select
	// ------------------------------------------------------------------
	// divide by 1, 2, 4, 8
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			out_pulse <= 1'b0;
		end else begin
			out_pulse <= rise[div_sel] & ~clear;
		end
	end

endmodule

// [core/stc_timer.sv]
`timescale 1ns/1ps

module stc_timer
	import stc_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              arst_n,
	input  wire logic              soft_rst_n,
	input  wire logic              sleep_mode,
	input  wire logic              osc_input_pin,
	input  wire logic              ext_clock_pin,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	output logic                   overflow_flag,
	output logic                   overflow_irq_enable,
	output logic                   osc_enable
);

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	logic rst_ff1_r;
	logic rst_ff2_r;
	logic rst_n;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_ff1_r <= 1'b0;
			rst_ff2_r <= 1'b0;
		end else begin
			rst_ff1_r <= 1'b1;
			rst_ff2_r <= rst_ff1_r;
		end
	end

	assign rst_n = rst_ff2_r;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [CTL_W-1:0]      ctrl_r;
	logic [CNT_W-1:0]      count_r;
	logic [QDIV_W-1:0]     qdiv_r;
	logic                  qtick_r;
	logic                  pin_prev_r;
	logic                  armed_r;
	logic                  sync_a_r;
	logic                  sync_b_r;
	logic                  counter_on;
	logic                  clk_src_sel;
	logic                  sync_dis_n;
	logic                  osc_en_bit;
	logic [PRESCALE_W-1:0] prescale_sel;
	logic                  wr_ctrl;
	logic                  wr_low;
	logic                  wr_high;
	logic                  wr_flag;
	logic                  wr_enable;
	logic                  osc_en_change;
	logic                  pin_lvl;
	logic                  pin_rise;
	logic                  pin_fall;
	logic                  pre_in;
	logic                  pre_out;
	logic                  pre_clear;
	logic                  sync_mode;
	logic                  inc;
	logic                  rollover;

	assign counter_on   = ctrl_r[BIT_COUNTER_ON];
	assign clk_src_sel  = ctrl_r[BIT_CLK_SRC_SEL];
	assign sync_dis_n   = ctrl_r[BIT_SYNC_DIS_N];
	assign osc_en_bit   = ctrl_r[BIT_OSC_ENABLE];
	assign prescale_sel = ctrl_r[BIT_PRESCALE_HI:BIT_PRESCALE_LO];

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	assign wr_ctrl   = reg_wr && (reg_addr == OFF_CONTROL);
	assign wr_low    = reg_wr && (reg_addr == OFF_COUNT_LOW);
	assign wr_high   = reg_wr && (reg_addr == OFF_COUNT_HIGH);
	assign wr_flag   = reg_wr && (reg_addr == OFF_FLAG_REG);
	assign wr_enable = reg_wr && (reg_addr == OFF_ENABLE_REG);

	assign osc_en_change = wr_ctrl && (reg_wdata[BIT_OSC_ENABLE] != osc_en_bit);

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------
	// Only the power-on path clears it; soft_rst_n leaves it alone.
	// control layout
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= CTL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= reg_wdata[CTL_W-1:0];
		end
	end

	// Oscillator driver follows the enable bit
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			osc_enable <= 1'b0;
		end else begin
			osc_enable <= osc_en_bit;
		end
	end

	// ------------------------------------------------------------------
	// Instruction clock
	// ------------------------------------------------------------------
	// The system oscillator stops in sleep, so the divide-by-four halts too.
	// oscillator over four
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			qdiv_r  <= QDIV_RST;
			qtick_r <= 1'b0;
		end else if (sleep_mode) begin
			qtick_r <= 1'b0;
		end else begin
			qdiv_r  <= qdiv_r + QDIV_ONE;
			qtick_r <= (qdiv_r == QDIV_LAST);
		end
	end

	// ------------------------------------------------------------------
	// External input and arming
	// ------------------------------------------------------------------
	// pin choice by osc_en_bit
	assign pin_lvl  = osc_en_bit ? osc_input_pin : ext_clock_pin;
	assign pin_rise = pin_lvl & ~pin_prev_r;
	assign pin_fall = ~pin_lvl & pin_prev_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev_r <= 1'b0;
		end else begin
			pin_prev_r <= pin_lvl;
		end
	end

	// Switching pins can fake an edge, so the source change disarms too.
	// wait for falling edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			armed_r <= 1'b0;
		end else if (!(counter_on && clk_src_sel) || osc_en_change) begin
			armed_r <= 1'b0;
		end else if (pin_fall) begin
			armed_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------------
	// count only while on
	assign pre_in = counter_on && (clk_src_sel ? (armed_r && pin_rise) : qtick_r);

	// A new configuration or count value restarts the division cleanly
	assign pre_clear = wr_ctrl || wr_low || wr_high;

	stc_prescaler #(
		.STAGES (PRESCALE_STAGES),
		.SEL_W  (PRESCALE_W)
	) u_prescaler (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.clear     (pre_clear),
		.in_pulse  (pre_in),
		.div_sel   (prescale_sel),
		.out_pulse (pre_out)
	);

	// ------------------------------------------------------------------
	// Synchroniser after the prescaler
	// ------------------------------------------------------------------
	// sync bit only in counter mode
	assign sync_mode = clk_src_sel && !sync_dis_n;

	// Two stages of latency; shut off in sleep, which drops its pulses.
	// sync after prescaler
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_a_r <= 1'b0;
			sync_b_r <= 1'b0;
		end else if (sleep_mode) begin
			sync_a_r <= 1'b0;
			sync_b_r <= 1'b0;
		end else begin
			sync_a_r <= pre_out;
			sync_b_r <= sync_a_r;
		end
	end

	// Pulses still in the prescaler or synchroniser when the counter is
	// switched off are dropped, so the count never moves while stopped.
	// no count in synced sleep
	assign inc = counter_on && (sync_mode ? (sync_b_r && !sleep_mode) : pre_out);

	// ------------------------------------------------------------------
	// Count
	// ------------------------------------------------------------------
	// A byte write wins over an increment in the same cycle.
	// byte access to count
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= CNT_RST;
		end else if (wr_low) begin
			count_r[DATA_W-1:0] <= reg_wdata;
		end else if (wr_high) begin
			count_r[CNT_W-1:DATA_W] <= reg_wdata;
		end else if (inc) begin
			count_r <= count_r + CNT_ONE;
		end
	end

	assign rollover = inc && !wr_low && !wr_high && (count_r == CNT_MAX);

	// ------------------------------------------------------------------
	// Flag and enable
	// ------------------------------------------------------------------
	// Rollover beats a clearing write or soft reset landing in the same cycle.
	// flag bit 0
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			overflow_flag <= 1'b0;
		end else if (rollover) begin
			overflow_flag <= 1'b1;
		end else if (!soft_rst_n) begin
			overflow_flag <= 1'b0;
		end else if (wr_flag) begin
			overflow_flag <= reg_wdata[BIT_OVF];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			overflow_irq_enable <= 1'b0;
		end else if (!soft_rst_n) begin
			overflow_irq_enable <= 1'b0;
		end else if (wr_enable) begin
			overflow_irq_enable <= reg_wdata[BIT_OVF];
		end
	end

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	// Data stand only in the cycle after the strobe; zero otherwise.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= RD_IDLE;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFF_COUNT_LOW: begin
					reg_rdata <= count_r[DATA_W-1:0];
				end
				OFF_COUNT_HIGH: begin
					reg_rdata <= count_r[CNT_W-1:DATA_W];
				end
				OFF_CONTROL: begin
					reg_rdata <= {{(DATA_W-CTL_W){1'b0}}, ctrl_r};
				end
				OFF_FLAG_REG: begin
					reg_rdata <= {{(DATA_W-1){1'b0}}, overflow_flag};
				end
				OFF_ENABLE_REG: begin
					reg_rdata <= {{(DATA_W-1){1'b0}}, overflow_irq_enable};
				end
				default: begin
					reg_rdata <= RD_IDLE;
				end
			endcase
		end else begin
			reg_rdata <= RD_IDLE;
		end
	end

endmodule
